// file: rtl/fp_sysreg_pkg.sv
/*
 * Constants shared by the floating-point system-register bank: transfer
 * select codes, field positions of the identity, status/control and
 * exception words, reset values and the rounding-mode encoding.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package fp_sysreg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register select codes carried by a coprocessor transfer
    localparam logic [3:0] SEL_IDENTITY   = 4'h0;
    localparam logic [3:0] SEL_STATUS     = 4'h1;
    localparam logic [3:0] SEL_EXCEPTION  = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Identity word layout
    localparam int ID_IMPL_LSB    = 24;
    localparam int ID_SOFT_BIT    = 23;
    localparam int ID_RSVD_MSB    = 22;
    localparam int ID_RSVD_LSB    = 21;
    localparam int ID_SINGLE_BIT  = 20;
    localparam int ID_ARCH_LSB    = 16;
    localparam int ID_PART_LSB    = 8;
    localparam int ID_VARIANT_LSB = 4;
    localparam int ID_REV_LSB     = 0;

    ////////////////////////////////////////////////////////////////////////
    // Status/control word layout
    localparam int SC_FLAG_N      = 31;
    localparam int SC_FLAG_Z      = 30;
    localparam int SC_FLAG_C      = 29;
    localparam int SC_FLAG_V      = 28;
    localparam int SC_DNAN_BIT    = 25;
    localparam int SC_FLUSH_BIT   = 24;
    localparam int SC_ROUND_LSB   = 22;
    localparam int SC_STEP_LSB    = 20;
    localparam int SC_COUNT_LSB   = 16;
    localparam int SC_IOE_BIT     = 8;
    localparam int SC_DZE_BIT     = 9;
    localparam int SC_OFE_BIT     = 10;
    localparam int SC_UFE_BIT     = 11;
    localparam int SC_IXE_BIT     = 12;
    localparam int SC_IDE_BIT     = 15;
    localparam int SC_IOC_BIT     = 0;
    localparam int SC_DZC_BIT     = 1;
    localparam int SC_OFC_BIT     = 2;
    localparam int SC_UFC_BIT     = 3;
    localparam int SC_IXC_BIT     = 4;
    localparam int SC_IDC_BIT     = 7;
    localparam logic [31:0] SC_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Exception word layout
    localparam int EX_STATE_BIT   = 31;
    localparam int EX_ENABLE_BIT  = 30;
    localparam logic [31:0] EX_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Vector length and step codes
    localparam logic [2:0] COUNT_SCALAR   = 3'h0;
    localparam logic [1:0] STEP_UNIT      = 2'h0;
    localparam logic [1:0] STEP_DOUBLE    = 2'h3;
    localparam logic [3:0] LEN_MAX_STEP2  = 4'h4;
    localparam logic [3:0] LEN_MAX_DBL    = 4'h4;
    localparam logic [3:0] LEN_MAX_DBL_S2 = 4'h2;

    // Rounding mode encoding
    typedef enum logic [1:0] {
        RND_NEAREST  = 2'b00,
        RND_PLUS_INF = 2'b01,
        RND_MINUS_INF = 2'b10,
        RND_ZERO     = 2'b11
    } rounding_type;

endpackage

// file: rtl/fp_identity_word.sv
/*
 * Builds the constant identity word from its fields.
 * Assumes the parameters are fixed at elaboration.
 */
`timescale 1ns/10ps
module fp_identity_word
    import fp_sysreg_pkg::*;
#(
    parameter logic [7:0] IMPLEMENTER = 8'h5a,  // Arbitrary value
    parameter logic       SOFT_ONLY   = 1'b0,
    parameter logic       SINGLE_ONLY = 1'b0,
    parameter logic [3:0] ARCH_CODE   = 4'h7,   // Arbitrary value
    parameter logic [7:0] PART_NUMBER = 8'h3c,  // Arbitrary value
    parameter logic [3:0] VARIANT     = 4'h2,   // Arbitrary value
    parameter logic [3:0] REVISION    = 4'h3    // Arbitrary value
) (
    output wire logic [31:0] word  // Identity word
);

    // Field packing, reserved pair forced to zero
    assign word = {IMPLEMENTER, SOFT_ONLY, 2'b00, SINGLE_ONLY,
                   ARCH_CODE, PART_NUMBER, VARIANT, REVISION};

endmodule // fp_identity_word

// file: rtl/vector_step_decode.sv
/*
 * Decodes the vector length and step fields into an element count,
 * a register spacing and legality flags.
 * Assumes fields come from a register on the same clock.
 */
`timescale 1ns/10ps
module vector_step_decode
    import fp_sysreg_pkg::*;
(
    input  wire logic [2:0] vector_count_field,  // Length code
    input  wire logic [1:0] step_field,          // Step code
    output logic      [3:0] length,              // Elements per operand
    output logic      [1:0] spacing,             // Register spacing
    output logic            scalar,              // Scalar mode in effect
    output logic            legal,               // Allowed combination
    output logic            dbl_ok               // Double vectors well defined
);

    // Count, spacing and legality of the combination
    always_comb begin
        length  = {1'b0, vector_count_field} + 4'h1;
        spacing = (step_field == STEP_DOUBLE) ? 2'h2 : 2'h1;
        scalar  = (vector_count_field == COUNT_SCALAR) && (step_field == STEP_UNIT);
        legal   = (step_field == STEP_UNIT) ||
                  ((step_field == STEP_DOUBLE) && (length >= 4'h2) &&
                   (length <= LEN_MAX_STEP2));
        dbl_ok  = legal && (length <= LEN_MAX_DBL) &&
                  ((step_field == STEP_UNIT) || (length <= LEN_MAX_DBL_S2));
    end

endmodule // vector_step_decode

// file: rtl/fp_unit_system_registers.sv
/*
 * System-register bank of a floating-point coprocessor: identity,
 * status/control and exception registers, comparison flag capture,
 * flag copy to the core, and per-operation rounding and vector decode.
 * Assumes the host core drives all inputs from logic on mclk, with
 * single-cycle transfer and event strobes.
 */
`timescale 1ns/10ps
module fp_unit_system_registers
    import fp_sysreg_pkg::*;
#(
    parameter logic [7:0] IMPLEMENTER = 8'h5a,  // Arbitrary value
    parameter logic       SOFT_ONLY   = 1'b0,
    parameter logic       SINGLE_ONLY = 1'b0,
    parameter logic [3:0] ARCH_CODE   = 4'h7,   // Arbitrary value
    parameter logic [7:0] PART_NUMBER = 8'h3c,  // Arbitrary value
    parameter logic [3:0] VARIANT     = 4'h2,   // Arbitrary value
    parameter logic [3:0] REVISION    = 4'h3    // Arbitrary value
) (
    input  wire logic        mclk,                // Processor clock
    input  wire logic        arst_n,              // Async reset, active low
    input  wire logic        xfer_valid,          // Register transfer strobe
    input  wire logic        xfer_write,          // 1 write, 0 read
    input  wire logic [3:0]  xfer_sel,            // Register select
    input  wire logic [31:0] xfer_wdata,          // Write data
    output logic      [31:0] xfer_rdata,          // Read data
    output logic             xfer_done,           // Transfer answered
    input  wire logic        cmp_valid,           // Comparison finished
    input  wire logic        cmp_less,            // Less-than result
    input  wire logic        cmp_equal,           // Equal result
    input  wire logic        cmp_unordered,       // Unordered result
    input  wire logic        flag_copy_op,        // Copy flags to core
    output logic      [3:0]  core_flags,          // N Z C V for the core
    output logic             core_flags_load,     // Load core_flags_reg
    input  wire logic        exc_valid,           // Exception flags strobe
    input  wire logic [5:0]  exc_flags,           // IO DZ OF UF IX ID
    input  wire logic        op_valid,            // Arithmetic op issued
    input  wire logic        op_double,           // Double precision op
    input  wire logic        op_trunc,            // Truncating conversion op
    input  wire logic [4:0]  op_dest,             // Destination register
    output logic      [1:0]  op_rounding,         // Rounding for this op
    output logic             op_vector,           // Op runs as vector
    output logic             op_unpredictable,    // Op result undefined
    output logic             default_nan_enable,  // Default-NaN mode
    output logic             flush_tiny_enable,   // Flush-to-zero mode
    output logic      [1:0]  rounding_select,     // Current rounding field
    output logic      [3:0]  vector_length,       // Elements per operand
    output logic      [1:0]  vector_spacing,      // Register spacing
    output logic             vector_legal,        // Allowed combination
    output logic      [5:0]  trap_enables,        // IO DZ OF UF IX ID
    output logic             fp_enable            // Exception reg enable bit
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] id_word;
    logic [31:0] status_q, status_d;
    logic [31:0] exc_q, exc_d;
    logic [31:0] rdata_q, rdata_d;
    logic        done_q, done_d;
    logic [3:0]  cflags_q, cflags_d;
    logic        cload_q, cload_d;
    logic [1:0]  oprnd_q, oprnd_d;
    logic        opvec_q, opvec_d;
    logic        opunp_q, opunp_d;
    logic [3:0]  vlen_q, vlen_d;
    logic [1:0]  vsp_q, vsp_d;
    logic        vleg_q, vleg_d;
    logic [3:0]  dec_len;
    logic [1:0]  dec_sp;
    logic        dec_scalar;
    logic        dec_legal;
    logic        dec_dbl_ok;
    logic        wr_status;
    logic        wr_exc;
    logic        low_bank;
    logic [31:0] sticky;

    ////////////////////////////////////////////////////////////////////////
    // Constant identity word
    fp_identity_word #(
        .IMPLEMENTER (IMPLEMENTER),
        .SOFT_ONLY   (SOFT_ONLY),
        .SINGLE_ONLY (SINGLE_ONLY),
        .ARCH_CODE   (ARCH_CODE),
        .PART_NUMBER (PART_NUMBER),
        .VARIANT     (VARIANT),
        .REVISION    (REVISION)
    ) u_identity (
        .word (id_word)
    );

    // Length and step decode of the stored fields
    vector_step_decode u_vector (
        .vector_count_field (status_q[SC_COUNT_LSB +: 3]),
        .step_field         (status_q[SC_STEP_LSB +: 2]),
        .length             (dec_len),
        .spacing            (dec_sp),
        .scalar             (dec_scalar),
        .legal              (dec_legal),
        .dbl_ok             (dec_dbl_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register writes, comparison capture and sticky exception flags
    always_comb begin
        wr_status = xfer_valid && xfer_write && (xfer_sel == SEL_STATUS);
        wr_exc    = xfer_valid && xfer_write && (xfer_sel == SEL_EXCEPTION);
        status_d  = wr_status ? xfer_wdata : status_q;
        exc_d     = wr_exc ? xfer_wdata : exc_q;
        // Latest comparison overrides a same-cycle write of the flags
        if (cmp_valid) begin
            status_d[SC_FLAG_N] = cmp_less;
            status_d[SC_FLAG_Z] = cmp_equal;
            status_d[SC_FLAG_C] = !cmp_less;
            status_d[SC_FLAG_V] = cmp_unordered;
        end
        // Sticky flags: a new event wins over a same-cycle clear
        sticky = 32'h0000_0000;
        sticky[SC_IOC_BIT] = exc_flags[0];
        sticky[SC_DZC_BIT] = exc_flags[1];
        sticky[SC_OFC_BIT] = exc_flags[2];
        sticky[SC_UFC_BIT] = exc_flags[3];
        sticky[SC_IXC_BIT] = exc_flags[4];
        sticky[SC_IDC_BIT] = exc_flags[5];
        if (exc_valid) begin
            status_d = status_d | sticky;
        end
    end

    // Register storage, reset to zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= SC_RESET;
            exc_q    <= EX_RESET;
        end else begin
            status_q <= status_d;
            exc_q    <= exc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path and transfer answer; identity ignores writes
    always_comb begin
        done_d  = xfer_valid;
        rdata_d = rdata_q;
        if (xfer_valid && !xfer_write) begin
            unique case (xfer_sel)
                SEL_IDENTITY:  rdata_d = id_word;
                SEL_STATUS:    rdata_d = status_q;
                SEL_EXCEPTION: rdata_d = exc_q;
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data and answer strobe
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
            done_q  <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            done_q  <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag copy to the core and per-operation decode
    always_comb begin
        cload_d  = flag_copy_op;
        cflags_d = flag_copy_op ? status_q[SC_FLAG_V +: 4] : cflags_q;
        low_bank = op_double ? (op_dest[4:2] == 3'h0) : (op_dest[4:3] == 2'h0);
        oprnd_d  = oprnd_q;
        opvec_d  = opvec_q;
        opunp_d  = opunp_q;
        if (op_valid) begin
            oprnd_d = op_trunc ? RND_ZERO : status_q[SC_ROUND_LSB +: 2];
            opvec_d = !dec_scalar && !low_bank;
            // Illegal combos and bad double vectors are flagged
            opunp_d = !dec_legal ||
                      (op_double && opvec_d && !dec_dbl_ok);
        end
        vlen_d = dec_len;
        vsp_d  = dec_sp;
        vleg_d = dec_legal;
    end

    // Operation decode registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cflags_q <= 4'h0;
            cload_q  <= 1'b0;
            oprnd_q  <= RND_NEAREST;
            opvec_q  <= 1'b0;
            opunp_q  <= 1'b0;
            vlen_q   <= 4'h1;
            vsp_q    <= 2'h1;
            vleg_q   <= 1'b1;
        end else begin
            cflags_q <= cflags_d;
            cload_q  <= cload_d;
            oprnd_q  <= oprnd_d;
            opvec_q  <= opvec_d;
            opunp_q  <= opunp_d;
            vlen_q   <= vlen_d;
            vsp_q    <= vsp_d;
            vleg_q   <= vleg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign xfer_rdata         = rdata_q;
    assign xfer_done          = done_q;
    assign core_flags         = cflags_q;
    assign core_flags_load    = cload_q;
    assign op_rounding        = oprnd_q;
    assign op_vector          = opvec_q;
    assign op_unpredictable   = opunp_q;
    assign default_nan_enable = status_q[SC_DNAN_BIT];
    assign flush_tiny_enable  = status_q[SC_FLUSH_BIT];
    assign rounding_select    = status_q[SC_ROUND_LSB +: 2];
    assign vector_length      = vlen_q;
    assign vector_spacing     = vsp_q;
    assign vector_legal       = vleg_q;
    assign trap_enables       = {status_q[SC_IDE_BIT], status_q[SC_IXE_BIT],
                                 status_q[SC_UFE_BIT], status_q[SC_OFE_BIT],
                                 status_q[SC_DZE_BIT], status_q[SC_IOE_BIT]};
    assign fp_enable          = exc_q[EX_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_ident_read_only: assert property (
        xfer_valid && !xfer_write && xfer_sel == SEL_IDENTITY
        |=> xfer_rdata == {IMPLEMENTER, SOFT_ONLY, 2'b00, SINGLE_ONLY,
                           ARCH_CODE, PART_NUMBER, VARIANT, REVISION})
        else $error("identity read wrong");

    a_ident_reserved: assert property (
        xfer_done && $past(xfer_sel) == SEL_IDENTITY && !$past(xfer_write)
        |-> xfer_rdata[ID_RSVD_MSB:ID_RSVD_LSB] == 2'b00)
        else $error("identity reserved bits set");

    // Back-to-back writes are legal, so the read check stands on its own
    a_status_write: assert property (
        wr_status && !cmp_valid && !exc_valid
        |=> status_q == $past(xfer_wdata))
        else $error("status write not held");

    a_status_read: assert property (
        xfer_valid && !xfer_write && xfer_sel == SEL_STATUS
        |=> xfer_rdata == $past(status_q))
        else $error("status read wrong");

    a_cmp_flags: assert property (
        cmp_valid |=> status_q[31:28] ==
            {$past(cmp_less), $past(cmp_equal), !$past(cmp_less), $past(cmp_unordered)})
        else $error("comparison flags wrong");

    a_flag_copy: assert property (
        flag_copy_op |=> core_flags_load && core_flags == $past(status_q[31:28]))
        else $error("flag copy wrong");

    a_copy_only: assert property (
        !flag_copy_op |=> !core_flags_load && $stable(core_flags))
        else $error("core flags moved without copy");

    a_trunc_round: assert property (
        op_valid && op_trunc |=> op_rounding == 2'b11)
        else $error("truncating op not toward zero");

    a_field_round: assert property (
        op_valid && !op_trunc |=> op_rounding == $past(status_q[23:22]))
        else $error("op rounding not from field");

    a_scalar_mode: assert property (
        op_valid && status_q[18:16] == 3'h0 && status_q[21:20] == 2'h0 |=> !op_vector)
        else $error("scalar mode op ran as vector");

    a_low_bank: assert property (
        op_valid && !op_double && op_dest < 5'h08 |=> !op_vector)
        else $error("low bank op ran as vector");

    a_length_plus: assert property (
        ##1 vector_length == {1'b0, $past(status_q[18:16])} + 4'h1)
        else $error("vector length wrong");

    a_sticky_set: assert property (
        exc_valid && exc_flags[0] |=> status_q[0] ##1 !exc_valid && !wr_status |=> status_q[0])
        else $error("sticky flag lost");

    c_compare_copy: cover property (cmp_valid ##1 flag_copy_op ##1 core_flags_load);
    c_vector_op:    cover property (op_valid ##1 op_vector);
    c_double_bad:   cover property (op_valid && op_double ##1 op_unpredictable);
    c_set_wins:     cover property (exc_valid && wr_status && !xfer_wdata[0] && exc_flags[0]);

endmodule // fp_unit_system_registers

// file: sim/host_core_model.sv
/* Host core model: issues register transfers to the bank.
   Assumes the bank answers at the taking edge; the answer is sampled 1 ns later. */
`timescale 1ns/10ps
module host_core_model (
    input  wire logic        mclk,        // Processor clock
    output logic             xfer_valid,  // Transfer strobe
    output logic             xfer_write,  // 1 write, 0 read
    output logic      [3:0]  xfer_sel,    // Register select
    output logic      [31:0] xfer_wdata,  // Write data
    input  wire logic [31:0] xfer_rdata,  // Read data
    input  wire logic        xfer_done    // Transfer answered
);
    // Idle bus at time zero
    initial begin
        {xfer_valid, xfer_write, xfer_sel} = '0;
        xfer_wdata = 32'h5a5a_a5a5;
    end
    // One transfer: hold until the taking edge, then release
    task automatic xfer(input logic wr, input logic [3:0] sel, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
        @(posedge mclk);
        {xfer_valid, xfer_write, xfer_sel, xfer_wdata} <= {1'b1, wr, sel, wd};
        @(posedge mclk);
        xfer_valid <= 1'b0;
        xfer_wdata <= ~wd;  // Stale data is not left on the bus
        #1;
        rd = xfer_rdata;
        ok = (xfer_done === 1'b1);
    endtask
    // Field update that keeps all other bits as read
    task automatic rmw(input logic [3:0] sel, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] rd;
        logic        ok;
        xfer(1'b0, sel, 32'h0, rd, ok);
        xfer(1'b1, sel, (rd & ~m) | (v & m), rd, ok);
    endtask
endmodule // host_core_model

// file: sim/fp_unit_system_registers_bench.sv
/* Bench for the system-register bank: transfers, events and ops.
   Assumes the host core model drives the transfer port. */
`timescale 1ns/10ps
module fp_unit_system_registers_bench
    import fp_sysreg_pkg::*;
;
    logic        mclk, arst_n, xfer_valid, xfer_write, xfer_done, cmp_valid, cmp_less;
    logic        cmp_equal, cmp_unordered, flag_copy_op, core_flags_load, exc_valid;
    logic        op_valid, op_double, op_trunc, op_vector, op_unpredictable, ok;
    logic        default_nan_enable, flush_tiny_enable, vector_legal, fp_enable;
    logic [1:0]  op_rounding, rounding_select, vector_spacing;
    logic [3:0]  xfer_sel, core_flags, vector_length, prev;
    logic [4:0]  op_dest;
    logic [5:0]  exc_flags, trap_enables;
    logic [6:0]  cmp_case [4];
    logic [31:0] xfer_wdata, xfer_rdata, rd;
    logic [39:0] op_case [9];
    int          n_mismatch, check_count;
    localparam logic [31:0] ID_WORD = {8'h5a, 4'h0, 4'h7, 8'h3c, 4'h2, 4'h3};

    fp_unit_system_registers u_fp_unit_system_registers (.mclk, .arst_n, .xfer_valid,
        .xfer_write, .xfer_sel, .xfer_wdata, .xfer_rdata, .xfer_done, .cmp_valid, .cmp_less,
        .cmp_equal, .cmp_unordered, .flag_copy_op, .core_flags, .core_flags_load, .exc_valid,
        .exc_flags, .op_valid, .op_double, .op_trunc, .op_dest, .op_rounding, .op_vector,
        .op_unpredictable, .default_nan_enable, .flush_tiny_enable, .rounding_select,
        .vector_length, .vector_spacing, .vector_legal, .trap_enables, .fp_enable);
    host_core_model u_host_core_model (.mclk, .xfer_valid, .xfer_write, .xfer_sel,
        .xfer_wdata, .xfer_rdata, .xfer_done);

    // 25 MHz clock
    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic xf(input logic wr, input logic [3:0] sel, input logic [31:0] wd);
        u_host_core_model.xfer(wr, sel, wd, rd, ok);
        chk("xfer_done", 32'h1, {31'h0, ok});
    endtask
    task automatic rc(input logic [3:0] sel, input logic [31:0] exp, input string name);
        xf(1'b0, sel, 32'h0);
        chk(name, exp, rd);
    endtask
    // One-cycle event strobes {compare, copy, exception, op} with qualifiers
    task automatic fire(input logic [3:0] s, input logic [15:0] q);
        @(posedge mclk);
        {cmp_valid, flag_copy_op, exc_valid, op_valid} <= s;
        {cmp_less, cmp_equal, cmp_unordered, op_double, op_trunc, op_dest, exc_flags} <= q;
        @(posedge mclk);
        {cmp_valid, flag_copy_op, exc_valid, op_valid} <= 4'h0;
        #1;
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung transfer
    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {mclk, arst_n, cmp_valid, flag_copy_op, exc_valid, op_valid} = '0;
        {cmp_less, cmp_equal, cmp_unordered, op_double, op_trunc, op_dest, exc_flags} = '0;
        {n_mismatch, check_count, prev} = '0;
        cmp_case = '{7'h48, 7'h26, 7'h02, 7'h13};  // Less, equal, greater, unordered
        op_case = '{{32'h0, 8'h50}, {32'h0001_0000, 8'h26}, {32'h0001_0000, 8'h1c},
            {32'h0001_0000, 8'h8c}, {32'h0001_0000, 8'h92}, {32'h0032_0000, 8'h97},
            {32'h0032_0000, 8'h88}, {32'h0004_0000, 8'h9b}, {32'h0004_0000, 8'h42}};
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        #1;
        chk("vector reset", 7'h0b, {vector_length, vector_spacing, vector_legal});
        rc(SEL_STATUS, SC_RESET, "status reset");
        rc(SEL_EXCEPTION, 32'h0, "exception reset");
        rc(SEL_IDENTITY, ID_WORD, "identity");
        xf(1'b1, SEL_IDENTITY, ~ID_WORD);
        rc(SEL_IDENTITY, ID_WORD, "identity kept");
        rc(4'h5, 32'h0, "unmapped");
        xf(1'b1, SEL_STATUS, 32'hf3f3_9f9f);
        rc(SEL_STATUS, 32'hf3f3_9f9f, "status");
        chk("modes", 2'b11, {default_nan_enable, flush_tiny_enable});
        chk("traps", 6'h3f, trap_enables);
        chk("vector 4x2", 7'h25, {vector_length, vector_spacing, vector_legal});
        xf(1'b1, SEL_STATUS, 32'h0c0c_6060);
        rc(SEL_STATUS, 32'h0c0c_6060, "status inverse");
        chk("modes off", 2'b00, {default_nan_enable, flush_tiny_enable});
        chk("traps off", 6'h0, trap_enables);
        chk("vector 5x1", 7'h2b, {vector_length, vector_spacing, vector_legal});
        // Each rounding code, then a truncating conversion under it
        for (int r = 0; r < 4; r++) begin
            u_host_core_model.rmw(SEL_STATUS, 32'h00c0_0000, 32'(r) << 22);
            fire(4'h1, 16'h0);
            chk("op_rounding", r[1:0], op_rounding);
            chk("rounding_select", r[1:0], rounding_select);
            fire(4'h1, 16'h0800);
            chk("trunc rounding", 2'b11, op_rounding);
        end
        // Vector or scalar decision per length, step, precision and destination
        foreach (op_case[i]) begin
            xf(1'b1, SEL_STATUS, op_case[i][39:8]);
            fire(4'h1, {3'b0, op_case[i][7], 1'b0, op_case[i][6:2], 6'h0});
            chk("vector op", op_case[i][1:0], {op_vector, op_unpredictable});
        end
        xf(1'b1, SEL_STATUS, 32'h0);
        foreach (cmp_case[k]) begin
            fire(4'h8, {cmp_case[k][6:4], 13'h0});
            rc(SEL_STATUS, {cmp_case[k][3:0], 28'h0}, "compare flags");
            chk("core flags held", prev, core_flags);
            fire(4'h4, 16'h0);
            chk("flag copy", {1'b1, cmp_case[k][3:0]}, {core_flags_load, core_flags});
            prev = cmp_case[k][3:0];
        end
        fire(4'h2, 16'h0021);
        fire(4'h2, 16'h001e);
        rc(SEL_STATUS, 32'h3000_009f, "sticky flags");
        xf(1'b1, SEL_EXCEPTION, 32'h4000_0000);
        chk("fp_enable", 1'b1, fp_enable);
        rc(SEL_EXCEPTION, 32'h4000_0000, "exception");
        complete_run;
    end
endmodule // fp_unit_system_registers_bench
